// *** i2ct_pkg.sv ***
// Shared constants and types for the bus time-out and interrupt-enable block.
package i2ct_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LIMIT_W = 16;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned IV_W = 12;

  // Register byte offsets.
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_EN_SET   = 12'h008;
  localparam logic [11:0] OFS_EN_CLR   = 12'h00c;
  localparam logic [11:0] OFS_LIMIT    = 12'h010;
  localparam logic [11:0] OFS_DIV      = 12'h014;
  localparam logic [11:0] OFS_EN_STAT  = 12'h018;
  localparam logic [11:0] OFS_STAT_CLR = 12'h01c;

  // Enable, status and clear registers share one bit layout.
  localparam int unsigned BIT_HOST_WAIT      = 0;
  localparam int unsigned BIT_HOST_ARB_LOST  = 4;
  localparam int unsigned BIT_HOST_FRAMING   = 6;
  localparam int unsigned BIT_TARGET_WAIT    = 8;
  localparam int unsigned BIT_TARGET_NO_HOLD = 11;
  localparam int unsigned BIT_TARGET_UNSEL   = 15;
  localparam int unsigned BIT_SNOOP_READY    = 16;
  localparam int unsigned BIT_SNOOP_OVERRUN  = 17;
  localparam int unsigned BIT_SNOOP_IDLE     = 19;
  localparam int unsigned BIT_EVENT_GAP      = 24;
  localparam int unsigned BIT_CLOCK_LOW      = 25;

  // Time-out limit register fields.
  localparam int unsigned IV_LSB = 4;
  localparam int unsigned IV_MSB = 15;
  localparam logic [3:0]  EXPIRY_FIXED_NIBBLE = 4'hf;
  localparam logic [11:0] IV_RESET = 12'hfff;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [31:0] EN_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    WR_IDLE     = 2'b00,
    WR_GOT_ADDR = 2'b01,
    WR_RESP     = 2'b11,
    WR_GOT_DATA = 2'b10
  } i2ct_wr_e;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } i2ct_rd_e;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_BUSY = 1'b1
  } i2ct_bus_e;

endpackage

// *** i2ct_watch_if.sv ***
// Link between the register side and the bus watcher.
`timescale 1ns/1ns
interface i2ct_watch_if;
  logic        tick;
  logic [15:0] limit;
  logic        gap_expire;
  logic        low_expire;

  modport ctl (output tick, output limit, input gap_expire, input low_expire);
  modport mon (input tick, input limit, output gap_expire, output low_expire);
endinterface

// *** i2ct_bus_watch.sv ***
// Bus line synchroniser, event detector and the two time-out counters.
`timescale 1ns/1ns
module i2ct_bus_watch (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  i2ct_watch_if.mon wif
);

  typedef struct packed {
    logic [2:0]         scl_sync;
    logic [2:0]         sda_sync;
    logic               scl_lvl;
    logic               sda_lvl;
    i2ct_pkg::i2ct_bus_e bus_st;
    logic [15:0]        gap_cnt;
    logic               gap_armed;
    logic [15:0]        low_cnt;
    logic               low_armed;
    logic               gap_exp;
    logic               low_exp;
  } i2ct_watch_s;

  i2ct_watch_s s;
  i2ct_watch_s n;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        any_event;

  always_comb begin
    n = s;
    n.gap_exp = 1'b0;
    n.low_exp = 1'b0;
    n.scl_sync = {s.scl_sync[1:0], scl_pin};
    n.sda_sync = {s.sda_sync[1:0], sda_pin};
    // A line level is accepted only once the second and third stages agree.
    if (s.scl_sync[1] == s.scl_sync[2]) begin
      n.scl_lvl = s.scl_sync[2];
    end
    if (s.sda_sync[1] == s.sda_sync[2]) begin
      n.sda_lvl = s.sda_sync[2];
    end
    scl_rise = n.scl_lvl & ~s.scl_lvl;
    scl_fall = ~n.scl_lvl & s.scl_lvl;
    start_seen = s.scl_lvl & n.scl_lvl & s.sda_lvl & ~n.sda_lvl;
    stop_seen = s.scl_lvl & n.scl_lvl & ~s.sda_lvl & n.sda_lvl;
    any_event = scl_rise | scl_fall | start_seen | stop_seen;
    if (start_seen) begin
      n.bus_st = i2ct_pkg::BUS_BUSY;
    end else if (stop_seen) begin
      n.bus_st = i2ct_pkg::BUS_IDLE;
    end
    if (n.bus_st == i2ct_pkg::BUS_IDLE || any_event) begin
      n.gap_cnt = '0;
      n.gap_armed = 1'b1;
    end else if (wif.tick && s.gap_armed) begin
      if (s.gap_cnt >= wif.limit) begin
        n.gap_exp = 1'b1;
        n.gap_armed = 1'b0;
      end else begin
        n.gap_cnt = s.gap_cnt + 16'h0001;
      end
    end
    if (n.bus_st == i2ct_pkg::BUS_IDLE || n.scl_lvl) begin
      n.low_cnt = '0;
      n.low_armed = 1'b1;
    end else if (wif.tick && s.low_armed) begin
      if (s.low_cnt >= wif.limit) begin
        n.low_exp = 1'b1;
        n.low_armed = 1'b0;
      end else begin
        n.low_cnt = s.low_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl_lvl: 1'b1, sda_lvl: 1'b1,
             bus_st: i2ct_pkg::BUS_IDLE, gap_cnt: 16'h0000, gap_armed: 1'b1,
             low_cnt: 16'h0000, low_armed: 1'b1, gap_exp: 1'b0, low_exp: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign wif.gap_expire = s.gap_exp;
  assign wif.low_expire = s.low_exp;

endmodule

// *** i2ct_top.sv ***
// Register slave, clock divider and interrupt logic for the bus time-out block.
// What this block does
// - Ones written to enable-clear clear matching enables.
// - Enable-clear is write-only, reads return zero.
// - Bits 0,4,6 clear host interrupt enables.
// - Bits 8,11,15 clear target interrupt enables.
// - Bits 16,17,19 clear snoop interrupt enables.
// - Bits 24,25 clear both time-out enables.
// - Two independent time-out checks are provided.
// - Event gap longer than limit sets flag.
// - SCL low longer than limit sets flag.
// - Flag interrupts only while its enable set.
// - Low four limit bits read as ones.
// - Time-out is interval plus one, times sixteen.
// - Zero gives 16, all ones 65536 clocks.
// - Function clock is system clock over divider+1.
// - Enable-set sets enables and reads current state.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
module i2ct_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  output logic [31:0]      irq_enables,
  output logic             bus_event_gap_flag,
  output logic             clock_low_overrun_flag,
  output logic             irq
);

  localparam logic [31:0] HOST_BITS = (32'h1 << i2ct_pkg::BIT_HOST_WAIT)
                                    | (32'h1 << i2ct_pkg::BIT_HOST_ARB_LOST)
                                    | (32'h1 << i2ct_pkg::BIT_HOST_FRAMING);
  localparam logic [31:0] TARGET_BITS = (32'h1 << i2ct_pkg::BIT_TARGET_WAIT)
                                      | (32'h1 << i2ct_pkg::BIT_TARGET_NO_HOLD)
                                      | (32'h1 << i2ct_pkg::BIT_TARGET_UNSEL);
  localparam logic [31:0] SNOOP_BITS = (32'h1 << i2ct_pkg::BIT_SNOOP_READY)
                                     | (32'h1 << i2ct_pkg::BIT_SNOOP_OVERRUN)
                                     | (32'h1 << i2ct_pkg::BIT_SNOOP_IDLE);
  localparam logic [31:0] TIMEOUT_BITS = (32'h1 << i2ct_pkg::BIT_EVENT_GAP)
                                       | (32'h1 << i2ct_pkg::BIT_CLOCK_LOW);
  localparam logic [31:0] EN_DEFINED = HOST_BITS | TARGET_BITS | SNOOP_BITS | TIMEOUT_BITS;

  typedef struct packed {
    i2ct_pkg::i2ct_wr_e wr_st;
    i2ct_pkg::i2ct_rd_e rd_st;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic [11:0]        wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;
    logic [31:0]        en;
    logic [31:0]        status;
    logic [11:0]        interval;
    logic [15:0]        div;
    logic [15:0]        div_cnt;
    logic               tick;
    logic               irq;
  } i2ct_top_s;

  i2ct_top_s   s;
  i2ct_top_s   n;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_wr;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [31:0] bm;
  logic [31:0] stat_set;
  logic [31:0] stat_clr;
  logic [15:0] lim_m;

  i2ct_watch_if wif ();

  i2ct_bus_watch u_watch (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .scl_pin (scl_pin),
    .sda_pin (sda_pin),
    .wif     (wif)
  );

  function automatic logic addr_ok(input logic [11:0] a);
    if (a == i2ct_pkg::OFS_STATUS) begin
      return 1'b1;
    end else if (a == i2ct_pkg::OFS_EN_SET) begin
      return 1'b1;
    end else if (a == i2ct_pkg::OFS_EN_CLR) begin
      return 1'b1;
    end else if (a == i2ct_pkg::OFS_LIMIT) begin
      return 1'b1;
    end else if (a == i2ct_pkg::OFS_DIV) begin
      return 1'b1;
    end else if (a == i2ct_pkg::OFS_EN_STAT) begin
      return 1'b1;
    end else if (a == i2ct_pkg::OFS_STAT_CLR) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  always_comb begin
    n = s;
    aw_hs = s_axi_awvalid & s.awready;
    w_hs = s_axi_wvalid & s.wready;
    ar_hs = s_axi_arvalid & s.arready;
    do_wr = 1'b0;
    wa = s.wr_addr;
    wd = s.wr_data;
    bm = lane_mask(s.wr_strb);
    stat_clr = '0;
    lim_m = {s.interval, i2ct_pkg::EXPIRY_FIXED_NIBBLE};

    // Write address and data are accepted in either order.
    case (s.wr_st)
      i2ct_pkg::WR_IDLE: begin
        if (aw_hs && w_hs) begin
          do_wr = 1'b1;
          wa = s_axi_awaddr;
          wd = s_axi_wdata;
          bm = lane_mask(s_axi_wstrb);
        end else if (aw_hs) begin
          n.wr_addr = s_axi_awaddr;
          n.awready = 1'b0;
          n.wr_st = i2ct_pkg::WR_GOT_ADDR;
        end else if (w_hs) begin
          n.wr_data = s_axi_wdata;
          n.wr_strb = s_axi_wstrb;
          n.wready = 1'b0;
          n.wr_st = i2ct_pkg::WR_GOT_DATA;
        end
      end
      i2ct_pkg::WR_GOT_ADDR: begin
        if (w_hs) begin
          do_wr = 1'b1;
          wd = s_axi_wdata;
          bm = lane_mask(s_axi_wstrb);
        end
      end
      i2ct_pkg::WR_GOT_DATA: begin
        if (aw_hs) begin
          do_wr = 1'b1;
          wa = s_axi_awaddr;
        end
      end
      i2ct_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          n.bvalid = 1'b0;
          n.awready = 1'b1;
          n.wready = 1'b1;
          n.wr_st = i2ct_pkg::WR_IDLE;
        end
      end
      default: begin
        n.wr_st = i2ct_pkg::WR_IDLE;
      end
    endcase

    if (do_wr) begin
      n.awready = 1'b0;
      n.wready = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_ok(wa) ? i2ct_pkg::RESP_OKAY : i2ct_pkg::RESP_SLVERR;
      n.wr_st = i2ct_pkg::WR_RESP;
      if (wa == i2ct_pkg::OFS_EN_SET) begin
        n.en = s.en | (wd & bm & EN_DEFINED);
      end else if (wa == i2ct_pkg::OFS_EN_CLR) begin
        n.en = s.en & ~(wd & bm & EN_DEFINED);
      end else if (wa == i2ct_pkg::OFS_LIMIT) begin
        lim_m = (lim_m & ~bm[15:0]) | (wd[15:0] & bm[15:0]);
        n.interval = lim_m[i2ct_pkg::IV_MSB:i2ct_pkg::IV_LSB];
      end else if (wa == i2ct_pkg::OFS_DIV) begin
        n.div = (s.div & ~bm[15:0]) | (wd[15:0] & bm[15:0]);
      end else if (wa == i2ct_pkg::OFS_STAT_CLR) begin
        stat_clr = wd & bm & TIMEOUT_BITS;
      end
    end

    case (s.rd_st)
      i2ct_pkg::RD_IDLE: begin
        if (ar_hs) begin
          n.arready = 1'b0;
          n.rvalid = 1'b1;
          n.rd_st = i2ct_pkg::RD_DATA;
          n.rresp = addr_ok(s_axi_araddr) ? i2ct_pkg::RESP_OKAY : i2ct_pkg::RESP_SLVERR;
          n.rdata = '0;
          if (s_axi_araddr == i2ct_pkg::OFS_STATUS) begin
            n.rdata = s.status;
          end else if (s_axi_araddr == i2ct_pkg::OFS_EN_SET) begin
            n.rdata = s.en;
          end else if (s_axi_araddr == i2ct_pkg::OFS_LIMIT) begin
            n.rdata = {16'h0000, s.interval, i2ct_pkg::EXPIRY_FIXED_NIBBLE};
          end else if (s_axi_araddr == i2ct_pkg::OFS_DIV) begin
            n.rdata = {16'h0000, s.div};
          end else if (s_axi_araddr == i2ct_pkg::OFS_EN_STAT) begin
            n.rdata = s.status & s.en;
          end
        end
      end
      i2ct_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          n.rvalid = 1'b0;
          n.arready = 1'b1;
          n.rd_st = i2ct_pkg::RD_IDLE;
        end
      end
      default: begin
        n.rd_st = i2ct_pkg::RD_IDLE;
      end
    endcase

    if (s.div_cnt >= s.div) begin
      n.div_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.div_cnt = s.div_cnt + 16'h0001;
      n.tick = 1'b0;
    end

    stat_set = ({31'h0, wif.gap_expire} << i2ct_pkg::BIT_EVENT_GAP)
             | ({31'h0, wif.low_expire} << i2ct_pkg::BIT_CLOCK_LOW);
    // A flag raised in the same cycle as its clear stays set.
    n.status = (s.status & ~stat_clr) | stat_set;
    n.irq = |(n.status & n.en);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{wr_st: i2ct_pkg::WR_IDLE, rd_st: i2ct_pkg::RD_IDLE, awready: 1'b1,
             wready: 1'b1, bvalid: 1'b0, bresp: i2ct_pkg::RESP_OKAY, arready: 1'b1,
             rvalid: 1'b0, rresp: i2ct_pkg::RESP_OKAY, rdata: 32'h0000_0000,
             wr_addr: 12'h000, wr_data: 32'h0000_0000, wr_strb: 4'h0,
             en: i2ct_pkg::EN_RESET, status: 32'h0000_0000,
             interval: i2ct_pkg::IV_RESET, div: i2ct_pkg::DIV_RESET,
             div_cnt: 16'h0000, tick: 1'b0, irq: 1'b0};
    end else begin
      s <= n;
    end
  end

  // limit is interval and fixed nibble
  assign wif.tick = s.tick;
  assign wif.limit = {s.interval, i2ct_pkg::EXPIRY_FIXED_NIBBLE};

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign irq_enables = s.en;
  assign bus_event_gap_flag = s.status[i2ct_pkg::BIT_EVENT_GAP];
  assign clock_low_overrun_flag = s.status[i2ct_pkg::BIT_CLOCK_LOW];
  assign irq = s.irq;

endmodule

// *** i2ct_top_props.sv ***
// Concurrent checks on the top module ports of the bus time-out block.
`timescale 1ns/1ns
module i2ct_top_props (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        scl_pin,
  input  wire logic [31:0] irq_enables,
  input  wire logic        bus_event_gap_flag,
  input  wire logic        clock_low_overrun_flag,
  input  wire logic        irq
);
  localparam logic [31:0] DEF_MASK = 32'h030b_8951;
  logic [11:0] rd_ofs_r;
  logic [7:0]  quiet_r;
  logic        scl_q_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Cycles since the clock line last moved; no gap can expire sooner than the shortest limit.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_ofs_r <= 12'h000;
      quiet_r  <= 8'h00;
      scl_q_r  <= 1'b1;
    end else begin
      scl_q_r <= scl_pin;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_ofs_r <= s_axi_araddr;
      end
      if (scl_pin != scl_q_r) begin
        quiet_r <= 8'h00;
      end else if (quiet_r != 8'hff) begin
        quiet_r <= quiet_r + 8'h01;
      end
    end
  end

  // The interrupt is registered from the next status and enables, so it moves with them.
  chk_irq_from_mask:
    assert property (irq == ((bus_event_gap_flag && irq_enables[24]) ||
                             (clock_low_overrun_flag && irq_enables[25])))
    else $error("irq does not follow enabled flags");
  chk_undef_enables:
    assert property ((irq_enables & ~DEF_MASK) == 32'h0000_0000)
    else $error("undefined enable bit set");
  chk_enables_on_write:
    assert property (irq_enables != $past(irq_enables) |-> $rose(s_axi_bvalid))
    else $error("enables changed without a write");
  chk_flag_clear_write:
    assert property ($fell(bus_event_gap_flag) |-> $rose(s_axi_bvalid))
    else $error("gap flag dropped without a write");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  chk_limit_fixed:
    assert property ($rose(s_axi_rvalid) && rd_ofs_r == i2ct_pkg::OFS_LIMIT |->
                     s_axi_rdata[3:0] == 4'hf && s_axi_rdata[31:16] == 16'h0000)
    else $error("limit fixed nibble wrong");
  chk_enset_readback:
    assert property ($rose(s_axi_rvalid) && rd_ofs_r == i2ct_pkg::OFS_EN_SET |->
                     s_axi_rdata == $past(irq_enables))
    else $error("enable readback differs");
  chk_gap_min_time:
    assert property ($rose(bus_event_gap_flag) |-> quiet_r >= 8'h10)
    else $error("gap flag set too early");
  chk_low_needs_low:
    assert property ($rose(clock_low_overrun_flag) |-> $past(scl_pin, 6) == 1'b0)
    else $error("low flag set while clock high");
endmodule

bind i2ct_top i2ct_top_props u_i2ct_top_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .scl_pin(scl_pin),
  .irq_enables(irq_enables), .bus_event_gap_flag(bus_event_gap_flag),
  .clock_low_overrun_flag(clock_low_overrun_flag), .irq(irq)
);

// *** i2ct_bus_partner.sv ***
// Far-side bus master model: frames a start, holds the clock low, then stops.
`timescale 1ns/1ns
module i2ct_bus_partner (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [1:0] cmd,
  output logic            scl,
  output logic            sda
);
  typedef struct packed {
    logic scl_lo;
    logic sda_lo;
  } i2ct_line_s;
  i2ct_line_s st_r;
  i2ct_line_s st_nxt;

  // One line moves per cycle, so a start or stop is never read as a clock edge.
  always_comb begin
    st_nxt = st_r;
    case (cmd)
      2'd0: begin
        if (st_r.scl_lo)
          st_nxt.scl_lo = 1'b0;
        else
          st_nxt.sda_lo = 1'b0;
      end
      2'd1: begin
        if (st_r.scl_lo)
          st_nxt.scl_lo = 1'b0;
        else
          st_nxt.sda_lo = 1'b1;
      end
      default: begin
        if (st_r.sda_lo)
          st_nxt.scl_lo = 1'b1;
        else
          st_nxt.sda_lo = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Released lines float to the pull-up level.
  assign scl = !st_r.scl_lo;
  assign sda = !st_r.sda_lo;
endmodule

// *** i2ct_tb.sv ***
// Self-checking bench: register accesses over AXI4-Lite and time-out runs.
`timescale 1ns/1ns
module testbench;
  logic        clk_sys;
  logic        rst_b;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        scl;
  logic        sda;
  logic [31:0] en;
  logic        gap;
  logic        low;
  logic        irq;
  logic [1:0]  cmd;
  logic [31:0] m;
  int          n_errors;
  int          cmp_count;
  int          bits[11] = '{0, 4, 6, 8, 11, 15, 16, 17, 19, 24, 25};

  i2ct_top u_i2ct_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_pin(scl),
    .sda_pin(sda), .irq_enables(en), .bus_event_gap_flag(gap),
    .clock_low_overrun_flag(low), .irq(irq)
  );
  i2ct_bus_partner u_i2ct_bus_partner (
    .clk_sys(clk_sys), .rst_b(rst_b), .cmd(cmd), .scl(scl), .sda(sda)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic tmo(input bit done);
    if (!done) begin
      n_errors++;
      $display("[FAIL] handshake expected answer seen none");
      report_and_stop();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Address and data are offered together and each is released when taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit b_d;
    int n;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_d = 0;
    for (n = 0; n < 40 && !b_d; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        b_d = 1;
      end
    end
    tmo(b_d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit r_d;
    int n;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_d = 0;
    for (n = 0; n < 40 && !r_d; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        r_d = 1;
      end
    end
    tmo(r_d);
  endtask

  // Start, hold the clock high, then hold it low, and expect each expiry on time.
  task automatic run_to(input logic [11:0] iv, input logic [15:0] dv);
    int t;
    t = (int'(iv) + 1) * 16 * (int'(dv) + 1);
    wr(i2ct_pkg::OFS_EN_CLR, 32'h0300_0000, 2'b00);
    wr(i2ct_pkg::OFS_STAT_CLR, 32'h0300_0000, 2'b00);
    wr(i2ct_pkg::OFS_LIMIT, {16'h0, iv, 4'h0}, 2'b00);
    wr(i2ct_pkg::OFS_DIV, {16'h0, dv}, 2'b00);
    rd(i2ct_pkg::OFS_LIMIT, {16'h0, iv, 4'hf}, 2'b00);
    wr(i2ct_pkg::OFS_EN_SET, 32'h0100_0000, 2'b00);
    cmd <= 2'd1;
    cyc(t);
    chkb("gap early", 1'b0, gap);
    cyc(12);
    chkb("gap", 1'b1, gap);
    chkb("irq gap", 1'b1, irq);
    chkb("low high", 1'b0, low);
    cmd <= 2'd2;
    cyc(t);
    chkb("low early", 1'b0, low);
    cyc(12);
    chkb("low", 1'b1, low);
    wr(i2ct_pkg::OFS_EN_CLR, 32'h0100_0000, 2'b00);
    cyc(2);
    chkb("irq off", 1'b0, irq);
    wr(i2ct_pkg::OFS_EN_SET, 32'h0200_0000, 2'b00);
    cyc(2);
    chkb("irq low", 1'b1, irq);
    rd(i2ct_pkg::OFS_EN_STAT, 32'h0200_0000, 2'b00);
    rd(i2ct_pkg::OFS_STATUS, 32'h0300_0000, 2'b00);
    cmd <= 2'd0;
    cyc(6);
    wr(i2ct_pkg::OFS_STAT_CLR, 32'h0300_0000, 2'b00);
    cyc(t + 20);
    chkb("gap idle", 1'b0, gap);
    chkb("low idle", 1'b0, low);
    $display("test time-out %0d done", t);
  endtask

  initial begin
    {rst_b, awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, cmd} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(i2ct_pkg::OFS_LIMIT, 32'h0000_ffff, 2'b00);
    rd(i2ct_pkg::OFS_EN_SET, 32'h0, 2'b00);
    rd(i2ct_pkg::OFS_DIV, 32'h0, 2'b00);
    wr(12'h0f0, 32'h0, 2'b10);
    rd(12'h0f0, 32'h0, 2'b10);
    $display("test reset values done");
    m = 32'h030b_8951;
    wr(i2ct_pkg::OFS_EN_SET, m, 2'b00);
    foreach (bits[i]) begin
      wr(i2ct_pkg::OFS_EN_CLR, 32'h1 << bits[i], 2'b00);
      m[bits[i]] = 1'b0;
      rd(i2ct_pkg::OFS_EN_SET, m, 2'b00);
      chk("irq_enables", m, en);
      rd(i2ct_pkg::OFS_EN_CLR, 32'h0, 2'b00);
    end
    $display("test enable clear done");
    run_to(12'h000, 16'h0000);
    run_to(12'h001, 16'h0001);
    report_and_stop();
  end
endmodule
